// ---- hw/aiomc_top.sv ----
/*
 * Auxiliary input and relay controller with APB registers and interrupt.
 * Assumes keypad, bell and tamper inputs synchronous to mclk_i; aux_in_i high = contact closed.
 */
// The register addresses and register access over APB were decided locally.
// Functional notes
// - Config code: lead 2, mode, two-digit setting
// - Setting 01-99 holds relay; 00 toggles, except mode 3 where relay follows tamper
// - Mode 0: exit button or code opens door
// - Mode 1: code drives open relay, no exit
// - Modes 1-4: input selects normal or secure
// - Mode 2: bell key drives relay
// - Mode 3: tamper drives closed relay
// - Mode 4: code shunts sensor for setting
// - Mode 5: door monitor, setting max shunt
// - Mode 6: door monitor, setting forced delay
// - Accepted code: normal, three beeps, indicators
// - Mode 5: follow door, shunt, alarm expiry
// - Mode 6: forced door, delay, then relay
// - Mode 7: door held open past delay
// - Modes 8/9: input picks flashing indicator colour
`timescale 1ns/1ps
module aiomc_top
    import aiomc_pkg::*;
#(
    parameter int SEC_CYCLES = SEC_CYCLES_DEF
) (
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic             irq_o,
    input  wire logic        valid_code_i,
    input  wire logic        bell_key_i,
    input  wire logic        tamper_i,
    input  wire logic        aux_in_i,
    output logic             aux_relay_o,
    output logic             aux_relay_nc_o,
    output logic             secure_mode_o,
    output logic             door_led_green_o,
    output logic             door_led_red_o,
    output logic             mode_led_green_o,
    output logic             beep3_o
);
    typedef struct packed {
        logic [15:0]      cfg;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic [31:0]      prdata;
        logic             slverr;
        logic             relay;
        aiomc_mon_t       mon;
        logic             aux_q;
        logic             tamper_q;
        logic             door_ok;
        logic             flash;
        logic             secure;
        logic             led_g;
        logic             led_r;
        logic             beep;
        logic             primed;
    } aiomc_st_t;

    aiomc_st_t        st, nxt;
    logic             tick;
    logic             rel_load, rel_clr, rel_exp;
    logic             mon_load, mon_clr, mon_exp;
    logic [6:0]       rel_cnt, mon_cnt, setv, mon_val;
    logic [3:0]       mode;
    logic             setup, acc_wr, cfg_wr, cfg_ok;
    logic             door_open, open_rise, close_rise, tamper_rise;
    logic             rel_mode, rel_trig, ns_mode;
    logic [IRQ_W-1:0] ev;

    // ************************************************************
    // Seconds base and timers
    // ************************************************************
    aiomc_prescaler #(.CYCLES(SEC_CYCLES)) u_pre (
        .mclk_i (mclk_i), .rst_n_i (rst_n_i), .ce_i (ce_i), .tick_o (tick)
    );

    aiomc_sec_timer u_rel_tim (
        .mclk_i (mclk_i), .rst_n_i (rst_n_i), .ce_i (ce_i), .tick_i (tick),
        .load_i (rel_load), .load_val_i (setv), .clear_i (rel_clr),
        .count_o (rel_cnt), .expired_o (rel_exp)
    );

    aiomc_sec_timer u_mon_tim (
        .mclk_i (mclk_i), .rst_n_i (rst_n_i), .ce_i (ce_i), .tick_i (tick),
        .load_i (mon_load), .load_val_i (mon_val), .clear_i (mon_clr),
        .count_o (mon_cnt), .expired_o (mon_exp)
    );

    // ************************************************************
    // Decode
    // ************************************************************
    assign mode    = st.cfg[11:8];
    assign setv    = 7'(st.cfg[7:4]) * BCD_TEN + 7'(st.cfg[3:0]);
    assign mon_val = (setv == 7'h00) ? 7'h01 : setv;
    assign setup   = psel_i && !penable_i;
    assign acc_wr  = psel_i && penable_i && pwrite_i && ce_i;
    assign cfg_wr  = acc_wr && paddr_i == ADDR_CFG;
    assign cfg_ok  = pwdata_i[15:12] == CFG_LEAD && pwdata_i[11:8] <= BCD_MAX
                     && pwdata_i[7:4] <= BCD_MAX && pwdata_i[3:0] <= BCD_MAX;

    assign door_open   = !aux_in_i;
    // No edge before the first sample after reset, whatever the idle level
    assign open_rise   = st.primed && !aux_in_i && st.aux_q;
    assign close_rise  = st.primed && aux_in_i && !st.aux_q;
    assign tamper_rise = st.primed && tamper_i && !st.tamper_q;
    assign ns_mode     = mode >= MODE_CODE && mode <= MODE_SHUNT;
    assign rel_mode    = mode <= MODE_SHUNT || mode == MODE_LED_GRN || mode == MODE_LED_RED;

    always_comb begin
        case (mode)
            MODE_REX:     rel_trig = valid_code_i || close_rise;
            MODE_BELL:    rel_trig = bell_key_i;
            MODE_TAMPER:  rel_trig = tamper_rise;
            MODE_CODE, MODE_SHUNT, MODE_LED_GRN, MODE_LED_RED: rel_trig = valid_code_i;
            default:      rel_trig = 1'b0;
        endcase
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        nxt = st;
        ev = '0;
        rel_load = 1'b0;
        rel_clr = 1'b0;
        mon_load = 1'b0;
        mon_clr = 1'b0;
        nxt.beep = 1'b0;
        nxt.aux_q = aux_in_i;
        nxt.tamper_q = tamper_i;
        nxt.primed = 1'b1;
        nxt.flash = st.flash ^ tick;
        if (rel_mode) begin
            if (rel_trig) begin
                if (setv == 7'h00) begin
                    nxt.relay = ~st.relay;
                    rel_clr = 1'b1;
                end else begin
                    nxt.relay = 1'b1;
                    rel_load = 1'b1;
                end
            end else if (rel_exp) begin
                nxt.relay = 1'b0;
            end
            if (mode == MODE_TAMPER && setv == 7'h00) begin
                nxt.relay = tamper_i;
            end
            nxt.mon = MON_IDLE;
        end else begin
            if (mode == MODE_FORCED) begin
                if (valid_code_i) begin
                    nxt.door_ok = 1'b1;
                end else if (close_rise) begin
                    nxt.door_ok = 1'b0;
                end
            end
            case (st.mon)
                MON_IDLE: begin
                    if (mode == MODE_MONITOR) begin
                        nxt.relay = door_open;
                        if (valid_code_i) begin
                            nxt.mon = MON_SHUNT;
                            nxt.relay = 1'b0;
                            mon_load = 1'b1;
                        end
                    end else if (open_rise && (mode == MODE_AJAR || !st.door_ok)) begin
                        nxt.mon = MON_WAIT;
                        mon_load = 1'b1;
                        ev[IRQ_FORCED] = mode == MODE_FORCED;
                    end
                end
                MON_SHUNT: begin
                    nxt.relay = 1'b0;
                    if (close_rise) begin
                        nxt.mon = MON_IDLE;
                        mon_clr = 1'b1;
                    end else if (mon_exp) begin
                        nxt.mon = door_open ? MON_ALARM : MON_IDLE;
                        nxt.relay = door_open;
                    end
                end
                MON_WAIT: begin
                    if (mode == MODE_AJAR && close_rise) begin
                        nxt.mon = MON_IDLE;
                        mon_clr = 1'b1;
                    end else if (mon_exp) begin
                        nxt.mon = MON_ALARM;
                        nxt.relay = 1'b1;
                    end
                end
                MON_ALARM: begin
                    nxt.relay = 1'b1;
                    if (close_rise) begin
                        nxt.mon = MON_IDLE;
                        nxt.relay = 1'b0;
                    end
                end
                default: nxt.mon = MON_IDLE;
            endcase
            ev[IRQ_ALARM] = nxt.mon == MON_ALARM && st.mon != MON_ALARM;
        end
        nxt.secure = ns_mode && aux_in_i;
        nxt.led_g = st.flash && ((mode == MODE_LED_GRN) == door_open)
                    && (mode == MODE_LED_GRN || mode == MODE_LED_RED);
        nxt.led_r = st.flash && ((mode == MODE_LED_RED) == door_open)
                    && (mode == MODE_LED_GRN || mode == MODE_LED_RED);
        // Register access
        if (setup) begin
            nxt.prdata = '0;
            nxt.slverr = 1'b0;
            case (paddr_i)
                ADDR_CFG:  nxt.prdata[15:0] = st.cfg;
                ADDR_STAT: begin
                    nxt.prdata[STAT_RELCNT+:7] = rel_cnt;
                    nxt.prdata[STAT_MONCNT+:7] = mon_cnt;
                    nxt.prdata[STAT_RELAY]     = st.relay;
                    nxt.prdata[STAT_MON+:2]    = st.mon;
                    nxt.prdata[STAT_SECURE]    = st.secure;
                    nxt.prdata[STAT_AUXIN]     = aux_in_i;
                end
                ADDR_IRQ:  nxt.prdata[IRQ_W-1:0] = st.irq_stat;
                ADDR_MASK: nxt.prdata[IRQ_W-1:0] = st.irq_mask;
                default:   nxt.slverr = 1'b1;
            endcase
            nxt.slverr = nxt.slverr || (pwrite_i && paddr_i == ADDR_CFG && !cfg_ok);
        end
        if (cfg_wr && cfg_ok) begin
            nxt.cfg = pwdata_i[15:0];
            nxt.relay = 1'b0;
            nxt.mon = MON_IDLE;
            nxt.door_ok = 1'b0;
            nxt.led_g = 1'b0;
            nxt.led_r = 1'b0;
            rel_clr = 1'b1;
            mon_clr = 1'b1;
            nxt.beep = 1'b1;
            ev[IRQ_CFG] = 1'b1;
        end
        if (acc_wr && paddr_i == ADDR_MASK) begin
            nxt.irq_mask = pwdata_i[IRQ_W-1:0];
        end
        ev[IRQ_RELAY] = nxt.relay && !st.relay;
        // Set wins over write-one-to-clear
        nxt.irq_stat = st.irq_stat & ~((acc_wr && paddr_i == ADDR_IRQ) ?
                       pwdata_i[IRQ_W-1:0] : {IRQ_W{1'b0}});
        nxt.irq_stat = nxt.irq_stat | ev;
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            st     <= '0;
            st.cfg <= CFG_RESET;
        end else if (ce_i) begin
            st <= nxt;
        end
    end

    assign prdata_o         = st.prdata;
    assign pready_o         = ce_i;
    assign pslverr_o        = psel_i && penable_i && st.slverr;
    assign irq_o            = |(st.irq_stat & st.irq_mask);
    assign aux_relay_o      = st.relay;
    assign aux_relay_nc_o   = mode == MODE_TAMPER || (mode >= MODE_MONITOR && mode <= MODE_AJAR);
    assign secure_mode_o    = st.secure;
    assign door_led_green_o = st.led_g;
    assign door_led_red_o   = st.led_r;
    assign mode_led_green_o = !st.secure;
    assign beep3_o          = st.beep;

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_cfg_reject;
        @(posedge mclk_i) disable iff (!rst_n_i) (cfg_wr && !cfg_ok) |=> $stable(st.cfg);
    endproperty
    a_cfg_reject: assert property (p_cfg_reject) else $error("bad code changed config");
    property p_release_end;
        @(posedge mclk_i) disable iff (!rst_n_i)
            (ce_i && rel_mode && rel_exp && !rel_trig && !cfg_wr && mode != MODE_TAMPER)
            |=> !aux_relay_o;
    endproperty
    a_release_end: assert property (p_release_end) else $error("relay held past release");
    property p_rex;
        @(posedge mclk_i) disable iff (!rst_n_i)
            (ce_i && mode == MODE_REX && close_rise && setv != 7'h00 && !cfg_wr) |=> aux_relay_o;
    endproperty
    a_rex: assert property (p_rex) else $error("exit button ignored");
    property p_code;
        @(posedge mclk_i) disable iff (!rst_n_i)
            (ce_i && (mode == MODE_CODE || mode == MODE_SHUNT) && valid_code_i
             && setv != 7'h00 && !cfg_wr) |=> aux_relay_o ##0 (rel_cnt == $past(setv));
    endproperty
    a_code: assert property (p_code) else $error("code did not load relay time");
    property p_secure;
        @(posedge mclk_i) disable iff (!rst_n_i) ce_i |=> secure_mode_o == $past(ns_mode && aux_in_i);
    endproperty
    a_secure: assert property (p_secure) else $error("secure switch wrong");
    property p_bell;
        @(posedge mclk_i) disable iff (!rst_n_i)
            (ce_i && mode == MODE_BELL && bell_key_i && !cfg_wr)
            |=> aux_relay_o == ($past(setv) != 7'h00 || !$past(st.relay));
    endproperty
    a_bell: assert property (p_bell) else $error("bell key relay wrong");
    property p_tamper;
        @(posedge mclk_i) disable iff (!rst_n_i)
            (ce_i && mode == MODE_TAMPER && setv == 7'h00 && !cfg_wr) |=> aux_relay_o == $past(tamper_i);
    endproperty
    a_tamper: assert property (p_tamper) else $error("tamper relay wrong");
    property p_accept;
        @(posedge mclk_i) disable iff (!rst_n_i)
            (cfg_wr && cfg_ok) |=> beep3_o && !aux_relay_o && !door_led_green_o ##1 !beep3_o || !ce_i;
    endproperty
    a_accept: assert property (p_accept) else $error("accept sequence wrong");
    property p_follow;
        @(posedge mclk_i) disable iff (!rst_n_i)
            (ce_i && mode == MODE_MONITOR && st.mon == MON_IDLE && !valid_code_i && !cfg_wr)
            |=> aux_relay_o == $past(door_open);
    endproperty
    a_follow: assert property (p_follow) else $error("relay not following door");

    property p_delay_fire;
        @(posedge mclk_i) disable iff (!rst_n_i)
            (ce_i && st.mon == MON_WAIT && mon_exp && !close_rise && !cfg_wr)
            |=> aux_relay_o && st.mon == MON_ALARM;
    endproperty
    a_delay_fire: assert property (p_delay_fire) else $error("delay expiry missed");

    property p_led;
        @(posedge mclk_i) disable iff (!rst_n_i)
            (ce_i && mode == MODE_LED_GRN && door_open && !cfg_wr) |=> !door_led_red_o;
    endproperty
    a_led: assert property (p_led) else $error("indicator colour wrong");

    c_shunt: cover property (@(posedge mclk_i) st.mon == MON_SHUNT ##1 st.mon == MON_ALARM);
    c_ajar:  cover property (@(posedge mclk_i) mode == MODE_AJAR && st.mon == MON_ALARM);
    c_toggle: cover property (@(posedge mclk_i) rel_trig && setv == 7'h00 && st.relay);
endmodule : aiomc_top

// ---- hw/aiomc_pkg.sv ----
/*
 * Constants, register map, field layout and types of the auxiliary I/O controller.
 * Assumes a 200 MHz system clock and a 32-bit APB register bus.
 */
package aiomc_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0]  ADDR_CFG  = 8'h00;
    localparam logic [7:0]  ADDR_STAT = 8'h04;
    localparam logic [7:0]  ADDR_IRQ  = 8'h08;
    localparam logic [7:0]  ADDR_MASK = 8'h0C;
    localparam logic [15:0] CFG_RESET = 16'h2004;
    localparam logic [3:0]  CFG_LEAD  = 4'h2;
    localparam logic [3:0]  BCD_MAX   = 4'h9;
    localparam logic [6:0]  BCD_TEN   = 7'h0A;
    // Status word fields
    localparam int STAT_RELCNT = 0;
    localparam int STAT_MONCNT = 8;
    localparam int STAT_RELAY  = 16;
    localparam int STAT_MON    = 17;
    localparam int STAT_SECURE = 19;
    localparam int STAT_AUXIN  = 20;
    // Interrupt bits
    localparam int IRQ_W      = 4;
    localparam int IRQ_CFG    = 0;
    localparam int IRQ_RELAY  = 1;
    localparam int IRQ_ALARM  = 2;
    localparam int IRQ_FORCED = 3;
    // ************************************************************
    // Auxiliary modes
    // ************************************************************
    localparam logic [3:0] MODE_REX     = 4'h0;
    localparam logic [3:0] MODE_CODE    = 4'h1;
    localparam logic [3:0] MODE_BELL    = 4'h2;
    localparam logic [3:0] MODE_TAMPER  = 4'h3;
    localparam logic [3:0] MODE_SHUNT   = 4'h4;
    localparam logic [3:0] MODE_MONITOR = 4'h5;
    localparam logic [3:0] MODE_FORCED  = 4'h6;
    localparam logic [3:0] MODE_AJAR    = 4'h7;
    localparam logic [3:0] MODE_LED_GRN = 4'h8;
    localparam logic [3:0] MODE_LED_RED = 4'h9;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_HZ         = 200_000_000;
    localparam int SEC_TIME_S     = 1;
    localparam int SEC_CYCLES_DEF = CLK_HZ * SEC_TIME_S;

    typedef enum logic [1:0] {
        MON_IDLE  = 2'b00,
        MON_WAIT  = 2'b01,
        MON_SHUNT = 2'b10,
        MON_ALARM = 2'b11
    } aiomc_mon_t;
endpackage : aiomc_pkg

// ---- hw/aiomc_prescaler.sv ----
/*
 * One-second tick generator.
 * Assumes a free-running system clock; tick is a one-cycle pulse.
 */
`timescale 1ns/1ps
module aiomc_prescaler #(
    parameter int CYCLES = 200
) (
    input  wire logic mclk_i,
    input  wire logic rst_n_i,
    input  wire logic ce_i,
    output logic      tick_o
);
    typedef struct packed {
        logic [31:0] cnt;
        logic        tick;
    } aiomc_pre_t;

    aiomc_pre_t st, nxt;

    always_comb begin
        nxt = st;
        nxt.tick = 1'b0;
        if (st.cnt == 32'(CYCLES - 1)) begin
            nxt.cnt  = '0;
            nxt.tick = 1'b1;
        end else begin
            nxt.cnt = st.cnt + 32'h1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else if (ce_i) begin
            st <= nxt;
        end
    end

    assign tick_o = st.tick;
endmodule : aiomc_prescaler

// ---- hw/aiomc_sec_timer.sv ----
/*
 * Seconds down-counter with load, clear and one-cycle expiry pulse.
 * Assumes tick_i is a one-cycle pulse once per second.
 */
`timescale 1ns/1ps
module aiomc_sec_timer (
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic       ce_i,
    input  wire logic       tick_i,
    input  wire logic       load_i,
    input  wire logic [6:0] load_val_i,
    input  wire logic       clear_i,
    output logic [6:0]      count_o,
    output logic            expired_o
);
    typedef struct packed {
        logic [6:0] cnt;
        logic       run;
        logic       exp;
    } aiomc_tim_t;

    aiomc_tim_t st, nxt;

    always_comb begin
        nxt = st;
        nxt.exp = 1'b0;
        if (clear_i) begin
            nxt.cnt = '0;
            nxt.run = 1'b0;
        end else if (load_i) begin
            nxt.cnt = load_val_i;
            nxt.run = 1'b1;
        end else if (tick_i && st.run) begin
            // Expire one tick after zero: a free-running tick never cuts a second short
            if (st.cnt == 7'h00) begin
                nxt.run = 1'b0;
                nxt.exp = 1'b1;
            end else begin
                nxt.cnt = st.cnt - 7'h01;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else if (ce_i) begin
            st <= nxt;
        end
    end

    assign count_o   = st.cnt;
    assign expired_o = st.exp;
endmodule : aiomc_sec_timer

// ---- verif/aiomc_door_model.sv ----
/*
 * Door contact and tamper switch model.
 * Assumes the bench commands it just after rising edges.
 */
`timescale 1ns/1ps
module aiomc_door_model (
    input  wire logic mclk_i,
    input  wire logic open_i,
    input  wire logic tamper_i,
    output logic      aux_in_o,
    output logic      tamper_o
);
    initial aux_in_o = 1'b1;
    initial tamper_o = 1'b0;
    // A closed contact or a pressed button reads high
    always @(posedge mclk_i) begin
        aux_in_o <= !open_i;
        tamper_o <= tamper_i;
    end
endmodule : aiomc_door_model

// ---- verif/aiomc_top_test.sv ----
/*
 * Bench of the auxiliary I/O controller: APB tasks, read check queue.
 * Assumes the door model drives the auxiliary input and tamper pins.
 */
`timescale 1ns/1ps
module aiomc_top_test;
    import aiomc_pkg::*;
    localparam int SEC = 20;
    logic        mclk_i  = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        psel    = 1'b0;
    logic        pen     = 1'b0;
    logic        pwr     = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic        vcode   = 1'b0;
    logic        bell    = 1'b0;
    logic        dopen   = 1'b0;
    logic        tcmd    = 1'b0;
    logic        ce      = 1'b1;
    logic [31:0] prdata;
    logic        pready, pslverr, irq, aux_in, tamper, relay, nc;
    logic        secure, lg, lr, mg, beep, g, r, perr;
    logic [3:0]  s;
    logic [31:0] exp_q[$];
    int          errors = 0;
    int          checks_done = 0;
    int          m;

    aiomc_top #(.SEC_CYCLES(SEC)) dut (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq),
        .valid_code_i(vcode), .bell_key_i(bell), .tamper_i(tamper),
        .aux_in_i(aux_in), .aux_relay_o(relay), .aux_relay_nc_o(nc),
        .secure_mode_o(secure), .door_led_green_o(lg), .door_led_red_o(lr),
        .mode_led_green_o(mg), .beep3_o(beep));
    aiomc_door_model door (.mclk_i(mclk_i), .open_i(dopen), .tamper_i(tcmd),
        .aux_in_o(aux_in), .tamper_o(tamper));

    initial forever #2.5 mclk_i = ~mclk_i;

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : conclude

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_i);
        pen <= 1'b1;
        do @(posedge mclk_i); while (pready !== 1'b1);
        perr = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd

    task automatic pulse(input logic bell_key);
        @(posedge mclk_i);
        if (bell_key) bell <= 1'b1;
        else vcode <= 1'b1;
        @(posedge mclk_i);
        bell <= 1'b0;
        vcode <= 1'b0;
    endtask : pulse

    task automatic wait_relay(input logic v);
        for (int n = 0; n < 3 * SEC && relay !== v; n++) @(posedge mclk_i);
        #1 check({31'h0, relay}, {31'h0, v});
    endtask : wait_relay

    // Read data monitor takes the oldest note
    always @(posedge mclk_i) begin
        if (psel && pen && pready && !pwr) begin
            if (exp_q.size() == 0) check(prdata, 32'hFFFF_FFFF);
            else check(prdata, exp_q.pop_front());
        end
    end

    initial begin
        #200000;
        errors++;
        conclude();
    end

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        void'($urandom(7316));
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        rd(ADDR_CFG, 32'h0000_2004);
        rd(8'h10, 32'h0);
        check({31'h0, perr}, 32'h1);
        apb(1'b1, ADDR_CFG, 32'h0000_3105);
        check({31'h0, perr}, 32'h1);
        rd(ADDR_CFG, 32'h0000_2004);
        $display("test config done");
        s = 4'(2 + $urandom_range(7));
        apb(1'b1, ADDR_MASK, 32'h2);
        apb(1'b1, ADDR_CFG, {20'h2, 4'h1, 4'h0, s});
        check({31'h0, perr}, 32'h0);
        #1 check({31'h0, beep}, 32'h1);
        pulse(1'b0);
        #1 check({29'h0, relay, secure, mg}, 32'h6);
        check({31'h0, irq}, 32'h1);
        repeat (s * SEC - 2) @(posedge mclk_i);
        #1 check({31'h0, relay}, 32'h1);
        wait_relay(1'b0);
        rd(ADDR_IRQ, 32'h3);
        apb(1'b1, ADDR_IRQ, 32'hF);
        rd(ADDR_IRQ, 32'h0);
        #1 check({31'h0, irq}, 32'h0);
        $display("test release done");
        dopen <= 1'b1;
        for (m = 8; m <= 9; m++) begin
            apb(1'b1, ADDR_CFG, 32'h2000 | (m << 8));
            g = 1'b0;
            r = 1'b0;
            repeat (3 * SEC) begin
                @(posedge mclk_i);
                g |= lg;
                r |= lr;
            end
            check({30'h0, g, r}, (m == 8) ? 32'h2 : 32'h1);
        end
        pulse(1'b0);
        wait_relay(1'b1);
        pulse(1'b0);
        wait_relay(1'b0);
        $display("test led done");
        apb(1'b1, ADDR_CFG, 32'h2001);
        dopen <= 1'b0;
        wait_relay(1'b1);
        #1 check({30'h0, secure, nc}, 32'h0);
        wait_relay(1'b0);
        apb(1'b1, ADDR_CFG, 32'h2201);
        pulse(1'b1);
        wait_relay(1'b1);
        apb(1'b1, ADDR_CFG, 32'h2300);
        #1 check({31'h0, nc}, 32'h1);
        tcmd <= 1'b1;
        wait_relay(1'b1);
        tcmd <= 1'b0;
        wait_relay(1'b0);
        apb(1'b1, ADDR_CFG, 32'h2301);
        tcmd <= 1'b1;
        wait_relay(1'b1);
        tcmd <= 1'b0;
        wait_relay(1'b0);
        apb(1'b1, ADDR_CFG, 32'h2401);
        pulse(1'b0);
        wait_relay(1'b1);
        check({31'h0, nc}, 32'h0);
        wait_relay(1'b0);
        $display("test trigger done");
        for (m = 6; m <= 7; m++) begin
            apb(1'b1, ADDR_CFG, 32'h2001 | (m << 8));
            dopen <= 1'b1;
            wait_relay(1'b1);
            dopen <= 1'b0;
            wait_relay(1'b0);
        end
        apb(1'b1, ADDR_CFG, 32'h2501);
        dopen <= 1'b1;
        wait_relay(1'b1);
        dopen <= 1'b0;
        wait_relay(1'b0);
        pulse(1'b0);
        dopen <= 1'b1;
        repeat (3) @(posedge mclk_i);
        #1 check({31'h0, relay}, 32'h0);
        wait_relay(1'b1);
        @(posedge mclk_i);
        ce <= 1'b0;
        dopen <= 1'b0;
        repeat (5) @(posedge mclk_i);
        #1 check({31'h0, relay}, 32'h1);
        @(posedge mclk_i);
        ce <= 1'b1;
        wait_relay(1'b0);
        $display("test monitor done");
        conclude();
    end
endmodule : aiomc_top_test
